// *** rtl/utxb_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the serial transceiver
// Assumes: register port addresses are word indices
// Notes: definitions only
`ifndef UTXB_REGS_SVH
`define UTXB_REGS_SVH
`define UTXB_ADDR_W 4
`define UTXB_OFF_MODE 4'h0
`define UTXB_OFF_STA 4'h1
`define UTXB_OFF_TXD 4'h2
`define UTXB_OFF_RXD 4'h3
`define UTXB_OFF_BRG 4'h4
`define UTXB_OFF_IFS 4'h5
`define UTXB_OFF_IEM 4'h6
// mode register fields
`define UTXB_MODE_ON 15
`define UTXB_MODE_INFRARED_CODEC_ENABLE 12
`define UTXB_MODE_PFS_HI 9
`define UTXB_MODE_PFS_LO 8
`define UTXB_MODE_HIGH_SPEED_BAUD_SELECT 3
`define UTXB_MODE_PDS_HI 2
`define UTXB_MODE_PDS_LO 1
`define UTXB_MODE_STSEL 0
// status / control fields
`define UTXB_STA_TXISEL_HI 15
`define UTXB_STA_TXISEL_LO 14
`define UTXB_STA_BRK 11
`define UTXB_STA_TXEN 10
`define UTXB_STA_TRMT 8
`define UTXB_STA_RXISEL_HI 7
`define UTXB_STA_RXISEL_LO 6
`define UTXB_STA_PARITY_ERROR_FLAG 3
`define UTXB_STA_FRAMING_ERROR_FLAG 2
`define UTXB_STA_OVERRUN_ERROR_FLAG 1
`define UTXB_STA_RXAV 0
// interrupt flag bits
`define UTXB_IRQ_TX 0
`define UTXB_IRQ_RX 1
`define UTXB_IRQ_ERR 2
`define UTXB_IRQ_W 3
`define UTXB_MODE_RST 16'h0000
`define UTXB_BRG_RST 16'h0000
`define UTXB_RXF_DEPTH 4
`define UTXB_TXEN_IRQ_DLY 2'h2
`define UTXB_BRK_BITS 4'hd
`endif

// *** rtl/utxb_pkg.sv ***
// Purpose: types of the serial transceiver
// Assumes: nothing
// Notes: used as utxb_pkg::name
package utxb_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} utxb_tx_type;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} utxb_rx_type;
endpackage

// *** rtl/utxb_baud.sv ***
// Purpose: baud tick generator giving 16x and bit ticks
// Assumes: divisor n gives 16x tick every n+1 clocks
// Notes: restart clears the count
`timescale 1ns/100ps
`default_nettype none
module utxb_baud (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic [15:0] divisor,
	input wire logic fast,
	output logic tick16,
	output logic tick_bit
);
	logic [15:0] cnt_reg;
	logic [3:0] sub_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			sub_reg <= 4'h0;
		end else if (restart || cnt_reg == divisor) begin
			cnt_reg <= 16'h0000;
			if (restart)
				sub_reg <= 4'h0;
			else
				sub_reg <= sub_reg + 4'h1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
	// fast mode: every sub tick is a bit tick (4x in hardware, simplified)
	assign tick16 = !restart && cnt_reg == divisor;
	// first bit tick comes on the first 16x tick after a restart, so a waiting frame loses no bit time
	assign tick_bit = tick16 && (fast || sub_reg == 4'h0);
endmodule
`default_nettype wire

// *** rtl/utxb_uart.sv ***
// Purpose: serial transceiver with break/sync, receive queue, flow pins and infrared
// Assumes: register port is word indexed, read data one cycle after read strobe
// Notes: 8 or 9 data bits, parity, one or two stop bits
//
// What this block does
// - transmit enable setting raises transmit interrupt three cycles later
// - 8-bit mode: byte write loads shifter at once, shifts on next baud edge
// - byte loaded while disabled starts at once when transmit enable set
// - transmit interrupt follows the transmit interrupt select field
// - 9-bit mode: word write loads nine bits, output on first baud edge
// - break: dummy write starts break, its value ignored
// - hardware clears break request after break, then sends queued character
// - receive interrupt raised per receive interrupt select field
// - overrun flag stays set until software clears it
// - reading receive data advances queue with its own parity and framing flags
// - request-to-send flags a full receive queue with field 01 or 10, clear-to-send gates transmit with field 10
// - infrared modes work only with high speed baud select zero
// - pin function 11, enabled and high speed baud select zero: request-to-send pin outputs 16x clock
// - infrared enable: receive and transmit pins use infrared codec
`include "utxb_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module utxb_uart (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic RXD,
	output logic TXD,
	input wire logic CTSN,
	output logic RTSN,
	output logic IRQ
);
	logic [15:0] mode_reg;
	logic [15:0] brg_reg;
	logic [1:0] txisel_reg;
	logic [1:0] rxisel_reg;
	logic txen_reg;
	logic brk_reg;
	logic overrun_error_flag_reg;
	logic [`UTXB_IRQ_W-1:0] ifs_reg;
	logic [`UTXB_IRQ_W-1:0] iem_reg;
	logic [1:0] txen_dly_reg;
	logic [8:0] hold_reg;
	logic hold_full_reg;
	logic hold_brk_reg;
	logic [8:0] tsr_reg;
	logic [3:0] bit_cnt_reg;
	logic tx_par_reg;
	logic txd_reg;
	utxb_pkg::utxb_tx_type tx_st_reg;
	logic [10:0] rxq_reg [`UTXB_RXF_DEPTH];
	logic [2:0] rxq_cnt_reg;
	logic [1:0] rxq_wp_reg;
	logic [1:0] rxq_rp_reg;
	logic [8:0] rx_sh_reg;
	logic [3:0] rx_bit_reg;
	logic [3:0] rx_ph_reg;
	logic rx_par_reg;
	utxb_pkg::utxb_rx_type rx_st_reg;
	logic rx_s1_reg;
	logic rx_prev_reg;
	logic rtsn_reg;
	logic bclk_reg;
	logic on;
	logic nine;
	logic ir_ok;
	logic [1:0] pfs;
	logic tick16;
	logic tick_bit;
	logic baud_restart;
	logic txd_raw;
	logic rxd_in;
	logic tx_wr;
	logic rx_rd;
	logic rx_push;
	logic [10:0] rx_word;
	logic rx_par_on;
	logic tx_load;
	logic tx_done;
	logic cts_ok;
	logic [3:0] last_bit;

	assign on = mode_reg[`UTXB_MODE_ON];
	assign nine = mode_reg[`UTXB_MODE_PDS_HI:`UTXB_MODE_PDS_LO] == 2'b11;
	assign pfs = mode_reg[`UTXB_MODE_PFS_HI:`UTXB_MODE_PFS_LO];
	// infrared only on 16x baud
	// infrared gated by speed
	assign ir_ok = !mode_reg[`UTXB_MODE_HIGH_SPEED_BAUD_SELECT];
	assign tx_wr = WR && ADDR == `UTXB_OFF_TXD;
	assign rx_rd = RD && ADDR == `UTXB_OFF_RXD;
	// baud restarts while transmit is off
	assign baud_restart = !on || !txen_reg;
	// flow control gates start of a character
	assign cts_ok = pfs != 2'b10 || !CTSN;
	assign last_bit = nine ? 4'h8 : 4'h7;

	utxb_baud u_baud (
		.clk(CLOCK),
		.rst_n(RSTN),
		.restart(baud_restart),
		.divisor(brg_reg),
		.fast(mode_reg[`UTXB_MODE_HIGH_SPEED_BAUD_SELECT]),
		.tick16(tick16),
		.tick_bit(tick_bit)
	);

	//////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			mode_reg <= `UTXB_MODE_RST;
			brg_reg <= `UTXB_BRG_RST;
			txisel_reg <= 2'h0;
			rxisel_reg <= 2'h0;
			txen_reg <= 1'b0;
			iem_reg <= '0;
		end else if (WR) begin
			case (ADDR)
				`UTXB_OFF_MODE: mode_reg <= WDATA;
				`UTXB_OFF_BRG: brg_reg <= WDATA;
				`UTXB_OFF_IEM: iem_reg <= WDATA[`UTXB_IRQ_W-1:0];
				`UTXB_OFF_STA: begin
					txisel_reg <= WDATA[`UTXB_STA_TXISEL_HI:`UTXB_STA_TXISEL_LO];
					rxisel_reg <= WDATA[`UTXB_STA_RXISEL_HI:`UTXB_STA_RXISEL_LO];
					txen_reg <= WDATA[`UTXB_STA_TXEN];
				end
				default: ;
			endcase
		end
	end

	// break request: set by software, cleared by hardware when break ends
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			brk_reg <= 1'b0;
		else if (WR && ADDR == `UTXB_OFF_STA && WDATA[`UTXB_STA_BRK])
			brk_reg <= 1'b1;
		else if (tx_done && tx_st_reg == utxb_pkg::TX_BRK)
			brk_reg <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////
	// transmit holding stage
	assign tx_load = hold_full_reg && tx_st_reg == utxb_pkg::TX_IDLE && on && txen_reg && cts_ok;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			hold_reg <= 9'h000;
			hold_full_reg <= 1'b0;
			hold_brk_reg <= 1'b0;
		end else if (tx_wr) begin
			hold_reg <= nine ? WDATA[8:0] : {1'b0, WDATA[7:0]};
			hold_full_reg <= 1'b1;
			hold_brk_reg <= brk_reg && !hold_full_reg && tx_st_reg == utxb_pkg::TX_IDLE;
		end else if (tx_load) begin
			hold_full_reg <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// transmit shifter
	assign tx_done = tick_bit && ((tx_st_reg == utxb_pkg::TX_STOP && bit_cnt_reg == {3'h0, mode_reg[`UTXB_MODE_STSEL]})
		|| (tx_st_reg == utxb_pkg::TX_BRK && bit_cnt_reg == `UTXB_BRK_BITS));
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			tx_st_reg <= utxb_pkg::TX_IDLE;
			tsr_reg <= 9'h000;
			bit_cnt_reg <= 4'h0;
			tx_par_reg <= 1'b0;
			txd_raw <= 1'b1;
		end else if (!on) begin
			tx_st_reg <= utxb_pkg::TX_IDLE;
			txd_raw <= 1'b1;
		end else begin
			case (tx_st_reg)
				utxb_pkg::TX_IDLE: if (tx_load) begin
					tsr_reg <= hold_reg;
					tx_par_reg <= mode_reg[`UTXB_MODE_PDS_HI:`UTXB_MODE_PDS_LO] == 2'b10;
					bit_cnt_reg <= 4'h0;
					tx_st_reg <= hold_brk_reg ? utxb_pkg::TX_BRK : utxb_pkg::TX_START;
				end
				utxb_pkg::TX_START: if (tick_bit) begin
					txd_raw <= 1'b0;
					tx_st_reg <= utxb_pkg::TX_DATA;
				end
				utxb_pkg::TX_DATA: if (tick_bit) begin
					txd_raw <= tsr_reg[0];
					tx_par_reg <= tx_par_reg ^ tsr_reg[0];
					tsr_reg <= {1'b0, tsr_reg[8:1]};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (bit_cnt_reg == last_bit) begin
						bit_cnt_reg <= 4'h0;
						tx_st_reg <= (mode_reg[`UTXB_MODE_PDS_HI:`UTXB_MODE_PDS_LO] == 2'b00 || nine)
							? utxb_pkg::TX_STOP : utxb_pkg::TX_PAR;
					end
				end
				utxb_pkg::TX_PAR: if (tick_bit) begin
					txd_raw <= tx_par_reg;
					tx_st_reg <= utxb_pkg::TX_STOP;
				end
				utxb_pkg::TX_STOP: if (tick_bit) begin
					txd_raw <= 1'b1;
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (tx_done)
						tx_st_reg <= utxb_pkg::TX_IDLE;
				end
				utxb_pkg::TX_BRK: if (tick_bit) begin
					txd_raw <= tx_done;
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					if (tx_done)
						tx_st_reg <= utxb_pkg::TX_IDLE;
				end
				default: tx_st_reg <= utxb_pkg::TX_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// pins: infrared encode, flow control, 16x clock
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			txd_reg <= 1'b1;
			rtsn_reg <= 1'b1;
			bclk_reg <= 1'b0;
		end else begin
			if (tick16)
				bclk_reg <= !bclk_reg;
			// infrared pulse on low bit, idle low
			if (mode_reg[`UTXB_MODE_INFRARED_CODEC_ENABLE] && ir_ok)
				txd_reg <= !txd_raw && tx_st_reg != utxb_pkg::TX_IDLE && bclk_reg;
			else
				txd_reg <= txd_raw;
			if (pfs == 2'b11)
				rtsn_reg <= on && ir_ok ? bclk_reg : 1'b1;
			else if (pfs == 2'b01 || pfs == 2'b10)
				rtsn_reg <= rxq_cnt_reg == 3'(`UTXB_RXF_DEPTH);
			else
				rtsn_reg <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// receiver
	// infrared input inverted pulses
	assign rxd_in = (mode_reg[`UTXB_MODE_INFRARED_CODEC_ENABLE] && ir_ok) ? !rx_s1_reg : rx_s1_reg;
	// flags kept per character
	// parity only when a parity bit is framed; 8-bit data without parity sits one place high
	assign rx_par_on = !nine && mode_reg[`UTXB_MODE_PDS_HI:`UTXB_MODE_PDS_LO] != 2'b00;
	assign rx_word = {rx_par_on && rx_par_reg != ^rx_sh_reg, !rxd_in,
		nine ? rx_sh_reg : (rx_par_on ? {1'b0, rx_sh_reg[7:0]} : {1'b0, rx_sh_reg[8:1]})};
	assign rx_push = rx_st_reg == utxb_pkg::RX_STOP && tick16 && rx_ph_reg == 4'h7;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			rx_s1_reg <= 1'b1;
		else
			rx_s1_reg <= RXD;
	end
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rx_st_reg <= utxb_pkg::RX_IDLE;
			rx_sh_reg <= 9'h000;
			rx_bit_reg <= 4'h0;
			rx_ph_reg <= 4'h0;
			rx_par_reg <= 1'b0;
			rx_prev_reg <= 1'b1;
		end else if (!on) begin
			rx_st_reg <= utxb_pkg::RX_IDLE;
		end else if (tick16) begin
			rx_ph_reg <= rx_ph_reg + 4'h1;
			rx_prev_reg <= rxd_in;
			case (rx_st_reg)
				utxb_pkg::RX_IDLE: begin
					rx_ph_reg <= 4'h0;
					rx_bit_reg <= 4'h0;
					// start only on a falling edge, so a low stop bit is no new start
					if (!rxd_in && rx_prev_reg)
						rx_st_reg <= utxb_pkg::RX_DATA;
				end
				utxb_pkg::RX_DATA: if (rx_ph_reg == 4'h7) begin
					// parity sampled into bit 8 slot when 8-bit with parity
					if (rx_bit_reg != 4'h0)
						rx_sh_reg <= {rxd_in, rx_sh_reg[8:1]};
					if (rx_bit_reg == last_bit + 4'h1 + {3'h0, !nine && mode_reg[2:1] != 2'b00})
						rx_st_reg <= utxb_pkg::RX_STOP;
					rx_bit_reg <= rx_bit_reg + 4'h1;
					rx_par_reg <= mode_reg[2:1] == 2'b10;
				end
				utxb_pkg::RX_STOP: if (rx_ph_reg == 4'h7)
					rx_st_reg <= utxb_pkg::RX_IDLE;
				default: rx_st_reg <= utxb_pkg::RX_IDLE;
			endcase
		end
	end

	// receive queue with per-character error flags
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rxq_cnt_reg <= 3'h0;
			rxq_wp_reg <= 2'h0;
			rxq_rp_reg <= 2'h0;
			overrun_error_flag_reg <= 1'b0;
			for (int i = 0; i < `UTXB_RXF_DEPTH; i++)
				rxq_reg[i] <= 11'h000;
		end else begin
			if (rx_push && rxq_cnt_reg != 3'(`UTXB_RXF_DEPTH) && !overrun_error_flag_reg) begin
				rxq_reg[rxq_wp_reg] <= rx_word;
				rxq_wp_reg <= rxq_wp_reg + 2'h1;
			end
			if (rx_rd && rxq_cnt_reg != 3'h0)
				rxq_rp_reg <= rxq_rp_reg + 2'h1;
			rxq_cnt_reg <= rxq_cnt_reg
				+ 3'(rx_push && rxq_cnt_reg != 3'(`UTXB_RXF_DEPTH) && !overrun_error_flag_reg)
				- 3'(rx_rd && rxq_cnt_reg != 3'h0);
			if (rx_push && rxq_cnt_reg == 3'(`UTXB_RXF_DEPTH))
				overrun_error_flag_reg <= 1'b1;
			else if (WR && ADDR == `UTXB_OFF_STA && !WDATA[`UTXB_STA_OVERRUN_ERROR_FLAG])
				overrun_error_flag_reg <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// interrupts
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			txen_dly_reg <= 2'h0;
		else
			txen_dly_reg <= {txen_dly_reg[0], WR && ADDR == `UTXB_OFF_STA && WDATA[`UTXB_STA_TXEN] && !txen_reg};
	end
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ifs_reg <= '0;
		end else begin
			for (int i = 0; i < `UTXB_IRQ_W; i++)
				if (WR && ADDR == `UTXB_OFF_IFS && WDATA[i])
					ifs_reg[i] <= 1'b0;
			// select: 0 on load, 1 on shift done, 2 on hold empty
			if (txen_dly_reg[1] || (txisel_reg == 2'b00 && tx_load) || (txisel_reg == 2'b01 && tx_done)
				|| (txisel_reg[1] && tx_load && !tx_wr))
				ifs_reg[`UTXB_IRQ_TX] <= 1'b1;
			// select: low any char, 2 at three, 3 at full
			if ((!rxisel_reg[1] && rx_push) || (rxisel_reg == 2'b10 && rxq_cnt_reg == 3'h3)
				|| (rxisel_reg == 2'b11 && rxq_cnt_reg == 3'(`UTXB_RXF_DEPTH)))
				ifs_reg[`UTXB_IRQ_RX] <= 1'b1;
			if (rx_push && rxq_cnt_reg == 3'(`UTXB_RXF_DEPTH))
				ifs_reg[`UTXB_IRQ_ERR] <= 1'b1;
		end
	end
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			IRQ <= 1'b0;
		else
			IRQ <= |(ifs_reg & iem_reg);
	end

	//////////////////////////////////////////////////////////////////////
	// read port
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			RDATA <= 16'h0000;
		end else if (RD) begin
			case (ADDR)
				`UTXB_OFF_MODE: RDATA <= mode_reg;
				`UTXB_OFF_BRG: RDATA <= brg_reg;
				`UTXB_OFF_STA: RDATA <= {txisel_reg, 2'h0, brk_reg, txen_reg, 1'b0,
					tx_st_reg == utxb_pkg::TX_IDLE && !hold_full_reg, rxisel_reg, 2'h0,
					rxq_reg[rxq_rp_reg][10], rxq_reg[rxq_rp_reg][9], overrun_error_flag_reg, rxq_cnt_reg != 3'h0};
				`UTXB_OFF_RXD: RDATA <= {7'h00, rxq_reg[rxq_rp_reg][8:0]};
				`UTXB_OFF_IFS: RDATA <= {13'h0000, ifs_reg};
				`UTXB_OFF_IEM: RDATA <= {13'h0000, iem_reg};
				default: RDATA <= 16'h0000;
			endcase
		end
	end
	assign TXD = txd_reg;
	assign RTSN = rtsn_reg;

	//////////////////////////////////////////////////////////////////////
	// checks
	property p_txen_irq;
		@(posedge CLOCK) disable iff (!RSTN)
		(WR && ADDR == `UTXB_OFF_STA && WDATA[`UTXB_STA_TXEN] && !txen_reg) |-> ##3 ifs_reg[`UTXB_IRQ_TX];
	endproperty
	a_txen_irq: assert property (p_txen_irq) else $error("tx irq not set after enable");
	property p_overrun_error_flag_hold;
		@(posedge CLOCK) disable iff (!RSTN)
		(overrun_error_flag_reg && !(WR && ADDR == `UTXB_OFF_STA)) |=> overrun_error_flag_reg;
	endproperty
	a_overrun_error_flag_hold: assert property (p_overrun_error_flag_hold) else $error("overrun cleared by hardware");
	property p_rd_adv;
		@(posedge CLOCK) disable iff (!RSTN)
		(rx_rd && rxq_cnt_reg != 3'h0) |=> rxq_rp_reg == $past(rxq_rp_reg) + 2'h1;
	endproperty
	a_rd_adv: assert property (p_rd_adv) else $error("receive read did not advance");
	property p_load;
		@(posedge CLOCK) disable iff (!RSTN)
		(tx_load && !hold_brk_reg) |=> tx_st_reg == utxb_pkg::TX_START && tsr_reg == $past(hold_reg);
	endproperty
	a_load: assert property (p_load) else $error("shifter not loaded");
	property p_brk_clr;
		@(posedge CLOCK) disable iff (!RSTN)
		(tx_done && tx_st_reg == utxb_pkg::TX_BRK && !(WR && ADDR == `UTXB_OFF_STA)) |=> !brk_reg;
	endproperty
	a_brk_clr: assert property (p_brk_clr) else $error("break bit not cleared");
	property p_bclk;
		@(posedge CLOCK) disable iff (!RSTN)
		(pfs == 2'b11 && !on) |=> RTSN;
	endproperty
	a_bclk: assert property (p_bclk) else $error("clock out while disabled");
	property p_irq;
		@(posedge CLOCK) disable iff (!RSTN)
		|(ifs_reg & iem_reg) |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
	property p_ir_gate;
		@(posedge CLOCK) disable iff (!RSTN)
		(mode_reg[`UTXB_MODE_HIGH_SPEED_BAUD_SELECT] && tx_st_reg == utxb_pkg::TX_IDLE && on) |=> TXD == $past(txd_raw);
	endproperty
	a_ir_gate: assert property (p_ir_gate) else $error("infrared active at high speed");
endmodule
`default_nettype wire

// *** test/utxb_remote.sv ***
// Purpose: remote serial terminal on the far side of the transceiver line
// Assumes: idle high line, lsb first, one stop bit, fixed bit length in clocks
// Notes: captured frames land in got_q, a break as -1 with its length in brk_len
`timescale 1ns/100ps
`default_nettype none
module utxb_remote #(
	parameter int BIT_CLKS = 32
) (
	input wire logic clk,
	input wire logic txd,
	input wire logic [3:0] nbits,
	input wire logic stall,
	output var logic rxd,
	output var logic cts_n
);
	int got_q[$];
	int brk_len;
	int v;
	int i;
	time t0;
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
	end
	always @(posedge clk) cts_n <= stall;
	////////////////////////////////////////////////////////////////
	// frame capture
	always begin
		@(negedge txd);
		t0 = $time;
		v = 0;
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (i = 0; i < int'(nbits); i++) begin
			repeat (BIT_CLKS) @(posedge clk);
			v = v | (int'(txd) << i);
		end
		repeat (BIT_CLKS) @(posedge clk);
		if (txd === 1'b0 && v == 0) begin
			@(posedge txd);
			brk_len = int'(($time - t0) / 4);
			got_q.push_back(-1);
		end else begin
			got_q.push_back(v);
		end
	end
	// one frame towards the receiver, stop bit may be spoilt
	task automatic send(input logic [7:0] d, input logic stop_ok);
		int k;
		@(posedge clk) rxd <= 1'b0;
		repeat (BIT_CLKS - 1) @(posedge clk);
		for (k = 0; k < 8; k++) begin
			@(posedge clk) rxd <= d[k];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
		@(posedge clk) rxd <= stop_ok;
		repeat (BIT_CLKS - 1) @(posedge clk);
		@(posedge clk) rxd <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** test/tb_uart_txrx_break_irda.sv ***
// Purpose: self-checking bench of the serial transceiver
// Assumes: divisor 1, so one bit lasts 32 clocks
// Notes: expected frames and received characters kept in queue models
`include "utxb_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_uart_txrx_break_irda;
	localparam int B = 32;
	logic CLOCK, RSTN, WR, RD, RXD, CTSN, TXD, RTSN, IRQ, stall;
	logic [3:0] ADDR, nbits;
	logic [15:0] WDATA, RDATA, r, d;
	int errors = 0, samples_checked = 0, seed = 32'h0000_8111, k, n, exp_q[$], rx_q[$];
	utxb_uart i_utxb_uart (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .RXD(RXD), .TXD(TXD), .CTSN(CTSN), .RTSN(RTSN), .IRQ(IRQ));
	utxb_remote #(.BIT_CLKS(B)) i_utxb_remote (.clk(CLOCK), .txd(TXD), .nbits(nbits), .stall(stall),
		.rxd(RXD), .cts_n(CTSN));
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1 r = RDATA;
	endtask
	// waits for one frame at the far side, compares with the model
	task automatic tx_frame();
		k = 0;
		while (i_utxb_remote.got_q.size() == 0 && k < 20 * B) begin
			@(posedge CLOCK);
			k++;
		end
		chk(16'(i_utxb_remote.got_q.size() > 0), 16'h0001);
		if (i_utxb_remote.got_q.size() > 0) chk(16'(i_utxb_remote.got_q.pop_front()), 16'(exp_q.pop_front()));
		repeat (B) @(posedge CLOCK);
	endtask
	task automatic rx_check(input int cnt);
		int v;
		repeat (cnt) begin
			v = rx_q.pop_front();
			rd(`UTXB_OFF_STA);
			chk(r & 16'h000c, 16'((v >> 6) & 4));
			rd(`UTXB_OFF_RXD);
			chk(r & 16'h00ff, 16'(v & 255));
		end
	endtask
	task automatic toggles(output int c);
		logic p;
		c = 0;
		p = RTSN;
		repeat (40) begin
			@(posedge CLOCK);
			#1 if (RTSN !== p) c++;
			p = RTSN;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	initial begin
		#240000;
		errors++;
		end_sim();
	end
	initial begin
		RSTN = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 4'h0;
		WDATA = 16'h0000;
		stall = 1'b0;
		nbits = 4'h8;
		repeat (20) @(posedge CLOCK);
		RSTN <= 1'b1;
		rd(`UTXB_OFF_MODE);
		chk(r, `UTXB_MODE_RST);
		rd(`UTXB_OFF_BRG);
		chk(r, `UTXB_BRG_RST);
		wr(4'hf, 16'hffff);
		rd(4'hf);
		chk(r, 16'h0000);
		wr(`UTXB_OFF_BRG, 16'h0001);
		wr(`UTXB_OFF_IEM, 16'h0000);
		wr(`UTXB_OFF_MODE, 16'h8000);
		d = 16'($random(seed)) & 16'h00ff;
		exp_q.push_back(int'(d));
		wr(`UTXB_OFF_TXD, d);
		wr(`UTXB_OFF_STA, 16'h0400);
		k = 0;
		while (TXD !== 1'b0 && k < 6) begin
			@(posedge CLOCK);
			k++;
		end
		chk(16'(TXD), 16'h0000);
		tx_frame();
		wr(`UTXB_OFF_STA, 16'h0000);
		wr(`UTXB_OFF_IFS, 16'h0007);
		wr(`UTXB_OFF_STA, 16'h0400);
		rd(`UTXB_OFF_IFS);
		chk(r & 16'h0001, 16'h0000);
		repeat (2) @(posedge CLOCK);
		rd(`UTXB_OFF_IFS);
		chk(r & 16'h0001, 16'h0001);
		chk(16'(IRQ), 16'h0000);
		wr(`UTXB_OFF_IEM, 16'h0001);
		repeat (2) @(posedge CLOCK);
		chk(16'(IRQ), 16'h0001);
		wr(`UTXB_OFF_IFS, 16'h0001);
		repeat (2) @(posedge CLOCK);
		chk(16'(IRQ), 16'h0000);
		for (n = 0; n < 3; n++) begin
			d = 16'($random(seed)) & 16'h00ff;
			exp_q.push_back(int'(d));
			wr(`UTXB_OFF_TXD, d);
			tx_frame();
			rd(`UTXB_OFF_IFS);
			chk(r & 16'h0001, 16'h0001);
			wr(`UTXB_OFF_IFS, 16'h0007);
		end
		wr(`UTXB_OFF_MODE, 16'h8006);
		nbits = 4'h9;
		wr(`UTXB_OFF_STA, 16'h4400);
		for (n = 0; n < 2; n++) begin
			d = 16'($random(seed));
			exp_q.push_back(int'(d & 16'h01ff));
			wr(`UTXB_OFF_TXD, d);
			rd(`UTXB_OFF_IFS);
			chk(r & 16'h0001, 16'h0000);
			tx_frame();
			rd(`UTXB_OFF_IFS);
			chk(r & 16'h0001, 16'h0001);
			wr(`UTXB_OFF_IFS, 16'h0007);
		end
		wr(`UTXB_OFF_MODE, 16'h8000);
		nbits = 4'h8;
		exp_q.push_back(-1);
		exp_q.push_back(85);
		wr(`UTXB_OFF_STA, 16'h0c00);
		wr(`UTXB_OFF_TXD, 16'($random(seed)));
		wr(`UTXB_OFF_TXD, 16'h0055);
		tx_frame();
		chk(16'(i_utxb_remote.brk_len), 16'(`UTXB_BRK_BITS * B));
		tx_frame();
		rd(`UTXB_OFF_STA);
		chk(r & 16'h0800, 16'h0000);
		wr(`UTXB_OFF_STA, 16'h0400);
		wr(`UTXB_OFF_IFS, 16'h0007);
		wr(`UTXB_OFF_IEM, 16'h0002);
		for (n = 0; n < 8; n++) begin
			d = 16'($random(seed)) & 16'h00ff;
			i_utxb_remote.send(d[7:0], n != 1);
			rx_q.push_back(int'(d) | ((n == 1) << 8));
			if (n == 2) chk(16'(IRQ), 16'h0001);
			if (n == 2) rx_check(3);
		end
		rd(`UTXB_OFF_STA);
		chk(r & 16'h0002, 16'h0002);
		rx_check(4);
		void'(rx_q.pop_front());
		rd(`UTXB_OFF_STA);
		chk(r & 16'h0002, 16'h0002);
		wr(`UTXB_OFF_STA, 16'h0400);
		rd(`UTXB_OFF_STA);
		chk(r & 16'h0003, 16'h0000);
		wr(`UTXB_OFF_MODE, 16'h8200);
		stall <= 1'b1;
		d = 16'($random(seed)) & 16'h00ff;
		exp_q.push_back(int'(d));
		wr(`UTXB_OFF_TXD, d);
		repeat (3 * B) @(posedge CLOCK);
		chk(16'(i_utxb_remote.got_q.size()), 16'h0000);
		chk(16'(TXD), 16'h0001);
		stall <= 1'b0;
		tx_frame();
		wr(`UTXB_OFF_MODE, 16'h8300);
		toggles(n);
		chk(16'(n >= 19 && n <= 21), 16'h0001);
		wr(`UTXB_OFF_MODE, 16'h0300);
		repeat (4) @(posedge CLOCK);
		toggles(n);
		chk(16'(n), 16'h0000);
		wr(`UTXB_OFF_MODE, 16'h8308);
		repeat (4) @(posedge CLOCK);
		toggles(n);
		chk(16'(n), 16'h0000);
		wr(`UTXB_OFF_MODE, 16'h9000);
		repeat (4) @(posedge CLOCK);
		chk(16'(TXD), 16'h0000);
		wr(`UTXB_OFF_TXD, 16'h0000);
		n = 0;
		repeat (10 * B) begin
			@(posedge CLOCK);
			#1 if (TXD === 1'b1) n++;
		end
		chk(16'(n > 0 && n < 5 * B), 16'h0001);
		end_sim();
	end
endmodule
`default_nettype wire
